// >>> hw/block_register_transfer.v
`timescale 1ns/1ps
`include "block_transfer_defines.vh"

module block_register_transfer (
  input wire core_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire instr_valid,
  input wire [31:0] instr_word,
  input wire cond_pass,
  input wire [31:0] instr_addr,
  input wire [31:0] instr_base,
  output reg instr_ready_q,
  output reg [3:0] rf_rd_addr_q,
  output reg rf_rd_user_q,
  input wire [31:0] rf_rd_data,
  output reg rf_wr_en_q,
  output reg [3:0] rf_wr_addr_q,
  output reg rf_wr_user_q,
  output reg [31:0] rf_wr_data_q,
  output reg status_restore_q,
  output reg mem_req_q,
  output reg mem_write_q,
  output reg [31:0] mem_addr_q,
  output reg [31:0] mem_wdata_q,
  output reg [1:0] cycle_kind_q,
  input wire [31:0] mem_rdata,
  input wire mem_abort,
  output reg done_q,
  output reg abort_trap_q
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_XFER = 3'h2;
  localparam [2:0] ST_LAST = 3'h3;
  localparam [2:0] ST_FILL_N = 3'h4;
  localparam [2:0] ST_FILL_S = 3'h5;

  reg [2:0] state_q;
  reg ctrl_en_q;
  reg [15:0] list_q;
  reg [15:0] rem_q;
  reg [3:0] base_idx_q;
  reg [3:0] cur_idx_q;
  reg load_q;
  reg wb_q;
  reg s_q;
  reg issue_left_q;
  reg aborted_q;
  reg [31:0] pc_q;
  reg [31:0] orig_base_q;
  reg [31:0] new_base_q;
  reg [31:0] addr_q;
  reg last_abort_q;
  reg last_skip_q;
  reg last_empty_q;
  reg [31:0] exec_count_q;
  reg [31:0] abort_count_q;
  reg [31:0] store_data;

  wire [15:0] scan_in;
  wire scan_any;
  wire [3:0] scan_idx;
  wire [4:0] scan_cnt;
  wire [31:0] start_addr;
  wire [31:0] wb_base;
  wire accept;
  wire issue_now;
  wire user_bank;
  wire apb_access;

  assign scan_in = (state_q == ST_IDLE) ? instr_word[`IW_LIST_MSB:0] : rem_q;
  assign accept = (state_q == ST_IDLE) & instr_valid & instr_ready_q;
  assign issue_now = (state_q == ST_SETUP) | ((state_q == ST_XFER) & issue_left_q);
  // User bank when the S bit is set, unless a load also restores status with the PC
  assign user_bank = instr_word[`IW_S_BIT] &
                     (~instr_word[`IW_LOAD_BIT] | ~instr_word[`IW_LIST_MSB]);
  assign apb_access = psel & penable & ~pready;

  reg_list_scan u_scan (
    .list(scan_in),
    .any(scan_any),
    .low_idx(scan_idx),
    .count(scan_cnt)
  );

  xfer_addr_gen u_addr (
    .base(instr_base),
    .count(scan_cnt),
    .pre(instr_word[`IW_PRE_BIT]),
    .up(instr_word[`IW_UP_BIT]),
    .start_addr(start_addr),
    .new_base(wb_base)
  );

  // Data for the register about to go on the bus
  always @* begin
    if (rf_rd_addr_q == `PC_IDX) begin
      store_data = pc_q + `PC_STORE_OFS;
    end else if (rf_rd_addr_q == base_idx_q && wb_q && state_q != ST_SETUP) begin
      store_data = new_base_q;
    end else begin
      store_data = rf_rd_data;
    end
  end

  // APB slave, one wait state per access
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl_en_q <= `CTRL_RESET;
    end else begin
      pready <= apb_access;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (apb_access) begin
        case (paddr)
          `CTRL_OFS: begin
            if (pwrite) begin
              ctrl_en_q <= pwdata[`CTRL_EN_BIT];
            end else begin
              prdata <= {31'h0, ctrl_en_q};
            end
          end
          `STATUS_OFS: begin
            prdata <= {28'h0, last_empty_q, last_skip_q, last_abort_q,
                       state_q != ST_IDLE};
          end
          `EXEC_COUNT_OFS: begin
            prdata <= exec_count_q;
          end
          `ABORT_COUNT_OFS: begin
            prdata <= abort_count_q;
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Transfer sequencer
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      instr_ready_q <= 1'b0;
      rf_rd_addr_q <= 4'h0;
      rf_rd_user_q <= 1'b0;
      rf_wr_en_q <= 1'b0;
      rf_wr_addr_q <= 4'h0;
      rf_wr_user_q <= 1'b0;
      rf_wr_data_q <= 32'h0;
      status_restore_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_write_q <= 1'b0;
      mem_addr_q <= 32'h0;
      mem_wdata_q <= 32'h0;
      cycle_kind_q <= `CYC_NONE;
      done_q <= 1'b0;
      abort_trap_q <= 1'b0;
      list_q <= 16'h0;
      rem_q <= 16'h0;
      base_idx_q <= 4'h0;
      cur_idx_q <= 4'h0;
      load_q <= 1'b0;
      wb_q <= 1'b0;
      s_q <= 1'b0;
      issue_left_q <= 1'b0;
      aborted_q <= 1'b0;
      pc_q <= 32'h0;
      orig_base_q <= 32'h0;
      new_base_q <= 32'h0;
      addr_q <= 32'h0;
      last_abort_q <= 1'b0;
      last_skip_q <= 1'b0;
      last_empty_q <= 1'b0;
      exec_count_q <= 32'h0;
      abort_count_q <= 32'h0;
    end else begin
      rf_wr_en_q <= 1'b0;
      status_restore_q <= 1'b0;
      done_q <= 1'b0;
      abort_trap_q <= 1'b0;
      if (done_q) begin
        exec_count_q <= exec_count_q + 32'h1;
      end
      if (abort_trap_q) begin
        abort_count_q <= abort_count_q + 32'h1;
      end

      // Put the next selected register on the bus
      if (issue_now) begin
        mem_req_q <= 1'b1;
        mem_write_q <= ~load_q;
        mem_addr_q <= addr_q;
        addr_q <= addr_q + `WORD_STEP;
        mem_wdata_q <= load_q ? 32'h0 : store_data;
        cur_idx_q <= rf_rd_addr_q;
        rf_rd_addr_q <= scan_idx;
        rem_q <= rem_q & (rem_q - 16'h1);
        issue_left_q <= scan_any;
        if (state_q == ST_SETUP && !load_q) begin
          cycle_kind_q <= `CYC_N;
        end else begin
          cycle_kind_q <= `CYC_S;
        end
      end

      case (state_q)
        ST_IDLE: begin
          instr_ready_q <= ctrl_en_q;
          cycle_kind_q <= `CYC_NONE;
          if (accept) begin
            if (!cond_pass || !scan_any) begin
              done_q <= 1'b1;
              last_skip_q <= ~cond_pass;
              last_empty_q <= cond_pass;
              last_abort_q <= 1'b0;
            end else begin
              instr_ready_q <= 1'b0;
              state_q <= ST_SETUP;
              cycle_kind_q <= `CYC_N;
              list_q <= instr_word[`IW_LIST_MSB:0];
              rem_q <= scan_in & (scan_in - 16'h1);
              rf_rd_addr_q <= scan_idx;
              rf_rd_user_q <= user_bank;
              base_idx_q <= instr_word[`IW_BASE_MSB:`IW_BASE_LSB];
              load_q <= instr_word[`IW_LOAD_BIT];
              wb_q <= instr_word[`IW_WB_BIT];
              s_q <= instr_word[`IW_S_BIT];
              pc_q <= instr_addr;
              orig_base_q <= instr_base;
              new_base_q <= wb_base;
              addr_q <= start_addr;
              aborted_q <= 1'b0;
              last_skip_q <= 1'b0;
              last_empty_q <= 1'b0;
            end
          end
        end
        ST_SETUP: begin
          state_q <= ST_XFER;
          // Base update lands at the end of the first transfer cycle
          if (wb_q) begin
            rf_wr_en_q <= 1'b1;
            rf_wr_addr_q <= base_idx_q;
            rf_wr_user_q <= 1'b0;
            rf_wr_data_q <= new_base_q;
          end
        end
        ST_XFER: begin
          aborted_q <= aborted_q | mem_abort;
          if (load_q && !mem_abort && !aborted_q) begin
            rf_wr_en_q <= 1'b1;
            rf_wr_addr_q <= cur_idx_q;
            rf_wr_user_q <= rf_rd_user_q;
            rf_wr_data_q <= mem_rdata;
            status_restore_q <= s_q & (cur_idx_q == `PC_IDX);
          end
          if (!issue_left_q) begin
            mem_req_q <= 1'b0;
            mem_write_q <= 1'b0;
            if (load_q) begin
              state_q <= ST_LAST;
              cycle_kind_q <= `CYC_I;
            end else begin
              state_q <= ST_IDLE;
              cycle_kind_q <= `CYC_NONE;
              instr_ready_q <= ctrl_en_q;
              done_q <= 1'b1;
              abort_trap_q <= aborted_q | mem_abort;
              last_abort_q <= aborted_q | mem_abort;
            end
          end
        end
        ST_LAST: begin
          if (aborted_q) begin
            rf_wr_en_q <= 1'b1;
            rf_wr_addr_q <= base_idx_q;
            rf_wr_user_q <= 1'b0;
            rf_wr_data_q <= wb_q ? new_base_q : orig_base_q;
            state_q <= ST_IDLE;
            cycle_kind_q <= `CYC_NONE;
            instr_ready_q <= ctrl_en_q;
            done_q <= 1'b1;
            abort_trap_q <= 1'b1;
            last_abort_q <= 1'b1;
          end else if (list_q[`IW_LIST_MSB]) begin
            state_q <= ST_FILL_N;
            cycle_kind_q <= `CYC_N;
          end else begin
            state_q <= ST_IDLE;
            cycle_kind_q <= `CYC_NONE;
            instr_ready_q <= ctrl_en_q;
            done_q <= 1'b1;
            last_abort_q <= 1'b0;
          end
        end
        ST_FILL_N: begin
          state_q <= ST_FILL_S;
          cycle_kind_q <= `CYC_S;
        end
        ST_FILL_S: begin
          state_q <= ST_IDLE;
          cycle_kind_q <= `CYC_NONE;
          instr_ready_q <= ctrl_en_q;
          done_q <= 1'b1;
          last_abort_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          cycle_kind_q <= `CYC_NONE;
        end
      endcase
    end
  end
endmodule // block_register_transfer

// >>> hw/block_transfer_defines.vh
`ifndef BLOCK_TRANSFER_DEFINES_VH
`define BLOCK_TRANSFER_DEFINES_VH

// Register offsets on the APB slave
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define EXEC_COUNT_OFS 12'h008
`define ABORT_COUNT_OFS 12'h00c

// Control fields and reset value
`define CTRL_EN_BIT 0
`define CTRL_RESET 1'b1

// Status fields
`define STAT_BUSY_BIT 0
`define STAT_ABORT_BIT 1
`define STAT_SKIP_BIT 2
`define STAT_EMPTY_BIT 3

// Instruction word fields
`define IW_LIST_MSB 15
`define IW_BASE_LSB 16
`define IW_BASE_MSB 19
`define IW_LOAD_BIT 20
`define IW_WB_BIT 21
`define IW_S_BIT 22
`define IW_UP_BIT 23
`define IW_PRE_BIT 24

// Register numbers and address steps
`define PC_IDX 4'hf
`define PC_STORE_OFS 32'h0000000c
`define WORD_STEP 32'h00000004

// Bus cycle kinds
`define CYC_NONE 2'h0
`define CYC_N 2'h1
`define CYC_S 2'h2
`define CYC_I 2'h3

`endif

// >>> hw/reg_list_scan.v
`timescale 1ns/1ps
`include "block_transfer_defines.vh"

module reg_list_scan (
  input wire [15:0] list,
  output wire any,
  output wire [3:0] low_idx,
  output wire [4:0] count
);
  wire [3:0] idx_chain [0:16];
  wire [4:0] cnt_chain [0:16];

  assign idx_chain[16] = 4'h0;
  assign cnt_chain[0] = 5'h00;

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      localparam [3:0] IDX = i;
      // Set bit n selects register n
      assign idx_chain[i] = list[i] ? IDX : idx_chain[i+1];
      assign cnt_chain[i+1] = cnt_chain[i] + {4'h0, list[i]};
    end
  endgenerate

  assign any = |list;
  assign low_idx = idx_chain[0];
  assign count = cnt_chain[16];
endmodule // reg_list_scan

// >>> hw/xfer_addr_gen.v
`timescale 1ns/1ps
`include "block_transfer_defines.vh"

module xfer_addr_gen (
  input wire [31:0] base,
  input wire [4:0] count,
  input wire pre,
  input wire up,
  output wire [31:0] start_addr,
  output wire [31:0] new_base
);
  wire [31:0] span;

  assign span = {25'h0, count, 2'b00};
  // Lowest register always takes the lowest address
  assign new_base = up ? base + span : base - span;
  assign start_addr = up ? (pre ? base + `WORD_STEP : base) :
                           (pre ? base - span : base - span + `WORD_STEP);
endmodule // xfer_addr_gen

// >>> tb/block_register_transfer_bench.sv
`timescale 1ns/1ps
`include "block_transfer_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module block_register_transfer_bench;
  logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, instr_word = 0, instr_base = 0, rf_rd_data;
  logic [31:0] instr_addr = 32'h200, rf_wr_data_q, mem_addr_q, mem_wdata_q, mem_rdata;
  logic [31:0] abort_addr = '1, rd, first_addr;
  logic instr_valid = 0, cond_pass = 0, instr_ready_q, rf_rd_user_q, rf_wr_en_q;
  logic rf_wr_user_q, status_restore_q, mem_req_q, mem_write_q, mem_abort;
  logic done_q, abort_trap_q, er, tr;
  logic [3:0] rf_rd_addr_q, rf_wr_addr_q;
  logic [1:0] cycle_kind_q;
  logic [31:0] rf [0:31];
  int bad_count = 0, comparisons = 0, cyc, nm, sr;
  always #2 core_clk = ~core_clk;
  block_register_transfer DUT (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .cond_pass(cond_pass), .instr_addr(instr_addr), .instr_base(instr_base),
    .instr_ready_q(instr_ready_q), .rf_rd_addr_q(rf_rd_addr_q), .rf_rd_user_q(rf_rd_user_q),
    .rf_rd_data(rf_rd_data), .rf_wr_en_q(rf_wr_en_q), .rf_wr_addr_q(rf_wr_addr_q),
    .rf_wr_user_q(rf_wr_user_q), .rf_wr_data_q(rf_wr_data_q),
    .status_restore_q(status_restore_q), .mem_req_q(mem_req_q), .mem_write_q(mem_write_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .cycle_kind_q(cycle_kind_q),
    .mem_rdata(mem_rdata), .mem_abort(mem_abort), .done_q(done_q),
    .abort_trap_q(abort_trap_q)
  );
  mem_model mm (
    .core_clk(core_clk), .mem_req_q(mem_req_q), .mem_write_q(mem_write_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .done_q(done_q),
    .abort_addr(abort_addr), .mem_rdata(mem_rdata), .mem_abort(mem_abort)
  );
  assign rf_rd_data = rf[{rf_rd_user_q, rf_rd_addr_q}];
  always @(posedge core_clk) if (rf_wr_en_q) rf[{rf_wr_user_q, rf_wr_addr_q}] <= rf_wr_data_q;
  task automatic results;
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      bad_count++;
      results();
    end
  endtask
  task automatic run(input logic [31:0] w, input logic c);
    int i;
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    cond_pass <= c;
    instr_base <= rf[{1'b0, w[19:16]}];
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (instr_ready_q === 1'b1) break;
    end
    instr_valid <= 1'b0;
    if (i == 50) begin
      bad_count++;
      results();
    end
    cyc = 0;
    nm = 0;
    sr = 0;
    tr = 0;
    first_addr = '1;
    for (i = 0; i < 100; i++) begin
      @(posedge core_clk);
      cyc++;
      if (mem_req_q && nm == 0) first_addr = mem_addr_q;
      nm += mem_req_q;
      sr += status_restore_q;
      tr |= abort_trap_q;
      if (done_q === 1'b1) break;
    end
    if (i == 100) begin
      bad_count++;
      results();
    end
  endtask
  initial begin
    for (int k = 0; k < 32; k++) rf[k] = 32'ha00 + k;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    apb(1'b0, `CTRL_OFS, 32'h0);
    `CHK(rd[`CTRL_EN_BIT], `CTRL_RESET)
    apb(1'b0, 12'h010, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    rf[1] <= 32'h100;
    run(32'h00a18022, 1'b1);
    `CHK({cyc, first_addr}, {32'd5, 32'h100})
    `CHK({mm.mem[64], mm.mem[65]}, {32'h100, 32'ha05})
    `CHK({mm.mem[66], rf[1]}, {32'h20c, 32'h10c})
    rf[3] <= 32'h200;
    run(32'h01230009, 1'b1);
    `CHK({mm.mem[126], mm.mem[127]}, {32'ha00, 32'h1f8})
    `CHK({rf[3], cyc}, {32'h1f8, 32'd4})
    rf[6] <= 32'h300;
    run(32'h01960014, 1'b1);
    `CHK({rf[2], rf[4]}, {32'h50c1, 32'h50c2})
    `CHK({rf[6], cyc}, {32'h300, 32'd5})
    rf[7] <= 32'h80;
    run(32'h003700c0, 1'b1);
    `CHK({rf[6], rf[7]}, {32'h501f, 32'h5020})
    rf[8] <= 32'h40;
    run(32'h00d88001, 1'b1);
    `CHK({rf[0], rf[15], sr, cyc}, {32'h5010, 32'h5011, 32'd1, 32'd7})
    rf[9] <= 32'h3c0;
    run(32'h00c90100, 1'b1);
    `CHK(mm.mem[240], 32'ha18)
    rf[1] <= 32'h140;
    abort_addr <= 32'h144;
    run(32'h00b10007, 1'b1);
    `CHK({rf[0], rf[1], rf[2]}, {32'h5050, 32'h14c, 32'h50c1})
    `CHK({tr, cyc}, {1'b1, 32'd6})
    apb(1'b0, `STATUS_OFS, 32'h0);
    `CHK(rd[`STAT_ABORT_BIT], 1'b1)
    rf[10] <= 32'h180;
    abort_addr <= 32'h180;
    run(32'h00aa0c00, 1'b1);
    `CHK({rf[10], tr}, {32'h188, 1'b1})
    `CHK({mm.mem[96], mm.mem[97]}, {32'h5060, 32'h5061})
    abort_addr <= '1;
    run(32'h00a18022, 1'b0);
    `CHK({cyc, nm, rf[1]}, {32'd1, 32'd0, 32'h14c})
    run(32'h00a10000, 1'b1);
    `CHK({cyc, nm, rf[1]}, {32'd1, 32'd0, 32'h14c})
    rf[12] <= 32'h3d2;
    run(32'h008c0001, 1'b1);
    `CHK({first_addr, rf[12]}, {32'h3d2, 32'h3d2})
    apb(1'b0, `EXEC_COUNT_OFS, 32'h0);
    `CHK(rd, 32'd11)
    apb(1'b0, `ABORT_COUNT_OFS, 32'h0);
    `CHK(rd, 32'd2)
    apb(1'b1, `CTRL_OFS, 32'h0);
    repeat (2) @(negedge core_clk);
    `CHK(instr_ready_q, 1'b0)
    results();
  end
endmodule // block_register_transfer_bench
bind block_register_transfer block_register_transfer_chk chk (
  .core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid),
  .instr_word(instr_word), .cond_pass(cond_pass), .instr_ready_q(instr_ready_q),
  .rf_wr_en_q(rf_wr_en_q), .rf_wr_addr_q(rf_wr_addr_q), .status_restore_q(status_restore_q),
  .mem_req_q(mem_req_q), .mem_write_q(mem_write_q), .mem_addr_q(mem_addr_q),
  .cycle_kind_q(cycle_kind_q), .mem_abort(mem_abort), .done_q(done_q),
  .abort_trap_q(abort_trap_q)
);

// >>> tb/block_register_transfer_chk.sv
`timescale 1ns/1ps
`include "block_transfer_defines.vh"
module block_register_transfer_chk (
  input wire core_clk,
  input wire reset_n,
  input wire instr_valid,
  input wire [31:0] instr_word,
  input wire cond_pass,
  input wire instr_ready_q,
  input wire rf_wr_en_q,
  input wire [3:0] rf_wr_addr_q,
  input wire status_restore_q,
  input wire mem_req_q,
  input wire mem_write_q,
  input wire [31:0] mem_addr_q,
  input wire [1:0] cycle_kind_q,
  input wire mem_abort,
  input wire done_q,
  input wire abort_trap_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire acc = instr_valid && instr_ready_q;
  wire wr = mem_req_q && mem_write_q;
  property p_skip; acc && !cond_pass |=> done_q && !mem_req_q; endproperty
  a_skip: assert property (p_skip) else $error("skip slow");
  property p_empty;
    acc && cond_pass && instr_word[15:0] == 16'h0 |=> done_q && !mem_req_q;
  endproperty
  a_empty: assert property (p_empty) else $error("empty list slow");
  property p_order; wr ##1 wr |-> mem_addr_q == $past(mem_addr_q) + 32'h4; endproperty
  a_order: assert property (p_order) else $error("bad address step");
  property p_first; wr && !$past(mem_req_q) |-> cycle_kind_q == `CYC_N; endproperty
  a_first: assert property (p_first) else $error("first store not N");
  property p_seq; mem_req_q && $past(mem_req_q) |-> cycle_kind_q == `CYC_S; endproperty
  a_seq: assert property (p_seq) else $error("burst not S");
  property p_ldab; mem_req_q && !mem_write_q && mem_abort |=> !rf_wr_en_q; endproperty
  a_ldab: assert property (p_ldab) else $error("aborted load written");
  property p_rest;
    status_restore_q |-> rf_wr_en_q && rf_wr_addr_q == `PC_IDX;
  endproperty
  a_rest: assert property (p_rest) else $error("restore without PC");
  property p_trap; abort_trap_q |-> done_q; endproperty
  a_trap: assert property (p_trap) else $error("trap before end");
  property p_abtr; mem_req_q && mem_abort |-> ##[1:20] abort_trap_q; endproperty
  a_abtr: assert property (p_abtr) else $error("no trap");
  c_trap: cover property (abort_trap_q);
  c_rest: cover property (status_restore_q);
  c_burst: cover property (wr ##1 wr);
endmodule // block_register_transfer_chk

// >>> tb/mem_model.sv
`timescale 1ns/1ps
module mem_model (
  input wire core_clk,
  input wire mem_req_q,
  input wire mem_write_q,
  input wire [31:0] mem_addr_q,
  input wire [31:0] mem_wdata_q,
  input wire done_q,
  input wire [31:0] abort_addr,
  output logic [31:0] mem_rdata,
  output logic mem_abort
);
  logic [31:0] mem [0:255];
  logic [31:0] last_q = 32'h0;
  logic sup_q = 1'b0;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h5000 + i;
  assign mem_abort = mem_req_q && mem_addr_q == abort_addr;
  assign mem_rdata = mem_req_q ? mem[mem_addr_q[9:2]] : ~last_q;
  always @(posedge core_clk) begin
    if (mem_req_q) last_q <= mem_rdata;
    if (mem_abort && mem_write_q) sup_q <= 1'b1;
    else if (done_q) sup_q <= 1'b0;
    if (mem_req_q && mem_write_q && !mem_abort && !sup_q) begin
      mem[mem_addr_q[9:2]] <= mem_wdata_q;
    end
  end
endmodule // mem_model
